// ===== design/bdr_defines.svh
`ifndef BDR_DEFINES_SVH
`define BDR_DEFINES_SVH
// Register offsets (low 16 address bits)
`define BDR_OFS_CTRL   16'h9004
`define BDR_OFS_RXPTR  16'h900c
`define BDR_OFS_LSZ    16'h9010
`define BDR_OFS_STAT   16'h9014
`define BDR_OFS_MASK   16'h9018
// Status bit positions
`define BDR_ST_DONE    0
`define BDR_ST_NULL    1
`define BDR_ST_NOWN    2
`define BDR_ST_MSO     3
`define BDR_ST_EMPTY   4
`define BDR_ST_EARLY   5
`define BDR_ST_W       6
// Control bit positions
`define BDR_CTRL_EN    0
`define BDR_CTRL_RST   1
`define BDR_CTRL_HALT  2
`define BDR_CTRL_SKIP  16
// Reset values
`define BDR_RXPTR_RST  26'h3ffffff
`define BDR_LSZ_RST    16'hffff
// Byte index of the length/type field within a frame
`define BDR_LEN_HI_IDX 16'h000c
`define BDR_LEN_LO_IDX 16'h000d
`endif

// ===== design/bdr_pkg.sv
// Purpose : Types shared by the receive DMA status block
// Assumes : 26-bit system addresses, byte-wide receive stream
// Notes   : Constants live in bdr_defines.svh
package bdr_pkg;
  typedef enum logic [2:0] {
    BDR_IDLE,
    BDR_FETCH,
    BDR_MOVE,
    BDR_DONE
  } bdr_fsm_t;

  typedef struct packed {
    logic        own;
    logic [25:0] buf_addr;
    logic [25:0] next_ptr;
  } bdr_desc_t;

  typedef struct packed {
    logic [25:0] addr;
    logic [7:0]  data;
  } bdr_memwr_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [31:0] data;
  } bdr_regwr_t;

  typedef struct packed {
    bdr_fsm_t    fsm;
    logic        en;
    logic        halt;
    logic        skip;
    logic [25:0] ptr;
    logic [15:0] lsz;
    logic [15:0] flen;
    logic [7:0]  len_hi;
    logic [5:0]  stat;
    logic [5:0]  mask;
    logic [15:0] cnt;
    logic [25:0] wptr;
    logic [25:0] nxt;
  } bdr_core_st_t;
endpackage

// ===== design/bdr_rx_buffer.sv
// Purpose : Internal receive buffer, flip-flop storage
// Assumes : DEPTH is a power of two
// Notes   : Honest full/empty via an extra pointer bit
module bdr_rx_buffer
  import bdr_pkg::*;
#(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,   // system clock
  input  wire logic         srst,      // sync reset
  input  wire logic         in_valid,  // write strobe
  input  wire logic [W-1:0] in_data,   // write data
  output logic              in_ready,  // not full
  output logic              out_valid, // not empty
  output logic [W-1:0]      out_data,  // head entry
  input  wire logic         out_ready  // pop strobe
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } bdr_fifo_st_t;

  bdr_fifo_st_t s_r;
  bdr_fifo_st_t s_nxt;
  logic         full;
  logic         empty;

  assign empty     = (s_r.wp == s_r.rp);
  assign full      = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== design/bdr_ahb_slave.sv
// Purpose : AHB-Lite slave front end for the register file
// Assumes : Single word transfers, zero wait states
// Notes   : Read data sampled at address phase, write at data phase
module bdr_ahb_slave
  import bdr_pkg::*;
(
  input  wire logic        clk_sys,   // system clock
  input  wire logic        srst,      // sync reset
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write flag
  input  wire logic [2:0]  hsize,     // transfer size
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic             hreadyout, // slave ready
  output logic             hresp,     // response
  output logic [31:0]      hrdata,    // read data
  output logic [15:0]      rd_addr,   // read address to core
  input  wire logic [31:0] rd_data,   // read data from core
  output bdr_regwr_t       reg_wr     // write request to core
);
  typedef struct packed {
    logic        wr_pend;
    logic [15:0] waddr;
    logic [31:0] rdata;
  } bdr_ahb_st_t;

  bdr_ahb_st_t s_r;
  bdr_ahb_st_t s_nxt;
  logic        acc;

  // Only whole-word transfers are accepted; any hsize other than word is ignored
  assign acc       = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign rd_addr   = haddr[15:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;
  assign reg_wr    = '{en: s_r.wr_pend, addr: s_r.waddr, data: hwdata};

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_pend = acc && hwrite;
    if (acc) begin
      s_nxt.waddr = haddr[15:0];
    end
    if (acc && !hwrite) begin
      s_nxt.rdata = rd_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== design/bdr_rx_dma.sv
// Purpose : Receive side of buffered DMA: size check, status, pointers
// Assumes : MAC stream and memory ports run on clk_sys
// Notes   : Summary of operation follows
//           Status bits are sticky: an event beats a write-one-to-clear
//           landing in the same cycle, so no event is ever lost
//           Halt is left only through the receive reset bit, which
//           also drops any frame in flight
//           Bytes past the limit are drained and never stored
//           The length reported is the frame's own length field,
//           not a count of bytes taken
//           The buffer fills whether or not the walk is enabled
// Summary of operation
// - Store at most programmed maximum bytes per frame
// - Set size-over flag when frame exceeds maximum
// - Expose current frame length in upper half
// - Set early flag once length field arrives
// - Set done flag per frame moved to memory
// - Done flag must clear before next interrupt
// - Set null flag when descriptor pointer is zero
// - Buffer keeps filling while receive DMA disabled
// - Not owner: flag, stop-skip, stop DMA
// - Set empty flag while buffer holds nothing
// - Advance descriptor pointer after each frame
`include "bdr_defines.svh"
module bdr_rx_dma
  import bdr_pkg::*;
#(
  parameter int BUF_DEPTH = 16
) (
  input  wire logic        clk_sys,      // system clock
  input  wire logic        srst,         // sync reset
  input  wire logic        hsel,         // AHB select
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hready,       // AHB ready in
  output logic             hreadyout,    // AHB ready out
  output logic             hresp,        // AHB response
  output logic [31:0]      hrdata,       // AHB read data
  input  wire logic        mac_valid,    // MAC byte valid
  input  wire logic [7:0]  mac_data,     // MAC byte
  input  wire logic        mac_last,     // last byte of frame
  output logic             mac_ready,    // buffer can take byte
  output logic             desc_rd_req,  // descriptor fetch
  output logic [25:0]      desc_rd_addr, // descriptor address
  input  wire logic        desc_rd_ack,  // descriptor answer
  input  wire bdr_desc_t   desc_rsp,     // descriptor content
  output logic             mem_wr_valid, // memory byte write
  output bdr_memwr_t       mem_wr,       // memory address/data
  input  wire logic        mem_wr_ready, // memory accepts
  output logic             irq           // level interrupt
);
  //--------------------------------------------------------------
  // Bus front end and receive buffer
  //--------------------------------------------------------------
  bdr_core_st_t s_r;
  bdr_core_st_t s_nxt;
  bdr_regwr_t   reg_wr;
  logic [15:0]  rd_addr;
  logic [31:0]  rd_data;
  logic         f_valid;
  logic [8:0]   f_data;
  logic         pop;
  logic [5:0]   ev;
  logic [5:0]   clr;
  logic         fits;
  logic         len_hi_hit;
  logic         len_lo_hit;
  logic         frm_end;

  bdr_ahb_slave u_ahb (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .reg_wr    (reg_wr)
  );

  // Filling is independent of the DMA enable; a full buffer
  // back-pressures the MAC instead of dropping bytes
  bdr_rx_buffer #(
    .W     (9),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (mac_valid),
    .in_data   ({mac_last, mac_data}),
    .in_ready  (mac_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (pop)
  );

  //--------------------------------------------------------------
  // Byte decode
  //--------------------------------------------------------------
  // The count runs over every popped byte, stored or drained, so
  // the length field is still found when the limit sits below it.
  // Limit writes apply at the next byte compared, even mid-frame;
  // software should halt first to avoid a frame cut short.
  assign fits       = (s_r.cnt < s_r.lsz);
  assign len_hi_hit = (s_r.cnt == `BDR_LEN_HI_IDX);
  assign len_lo_hit = (s_r.cnt == `BDR_LEN_LO_IDX);
  // Ninth buffer bit carries the last-byte mark
  assign frm_end    = f_data[8];

  //--------------------------------------------------------------
  // Register read mux
  //--------------------------------------------------------------
  // Control reads back enable, halt and stop-skip; the receive
  // reset bit is a strobe and reads as zero. Offsets with no
  // register read as zero and ignore writes.
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      `BDR_OFS_CTRL: begin
        rd_data[`BDR_CTRL_EN]   = s_r.en;
        rd_data[`BDR_CTRL_HALT] = s_r.halt;
        rd_data[`BDR_CTRL_SKIP] = s_r.skip;
      end
      `BDR_OFS_RXPTR: rd_data = {6'h0, s_r.ptr};
      `BDR_OFS_LSZ:   rd_data = {s_r.flen, s_r.lsz};
      `BDR_OFS_STAT:  rd_data = {26'h0, s_r.stat};
      `BDR_OFS_MASK:  rd_data = {26'h0, s_r.mask};
      default:        rd_data = 32'h0;
    endcase
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Fetch request and address stand for the whole fetch state
  assign desc_rd_req  = (s_r.fsm == BDR_FETCH);
  assign desc_rd_addr = s_r.ptr;
  assign mem_wr       = '{addr: s_r.wptr, data: f_data[7:0]};
  // Level output: a frame that completes while done is still set
  // raises no fresh event until software clears it
  assign irq          = |(s_r.stat & s_r.mask);

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    ev           = 6'h0;
    clr          = 6'h0;
    pop          = 1'b0;
    mem_wr_valid = 1'b0;

    //------------------------------------------------------------
    // Drain
    //------------------------------------------------------------
    ev[`BDR_ST_EMPTY] = !f_valid;

    // A stalled memory write keeps the byte at the buffer head
    if (s_r.fsm == BDR_MOVE && f_valid) begin
      if (fits) begin
        mem_wr_valid = 1'b1;
        pop          = mem_wr_ready;
      end else begin
        // Bytes past the limit are drained but never stored
        pop = 1'b1;
      end
    end

    //------------------------------------------------------------
    // Descriptor walk
    //------------------------------------------------------------
    // Idle waits for enable with halt clear; a zero pointer is a
    // null list and halts at once. Fetch holds the request until the
    // descriptor answers. Move counts every byte it pops, stored or
    // drained, until the last-byte mark. Done raises the done flag
    // and steps the pointer on, after which the walk goes round again
    // while enabled.
    unique case (s_r.fsm)
      BDR_IDLE: begin
        if (s_r.en && !s_r.halt) begin
          // Halting stops a null list from re-flagging every cycle
          if (s_r.ptr == 26'h0) begin
            ev[`BDR_ST_NULL] = 1'b1;
            s_nxt.halt       = 1'b1;
          end else begin
            s_nxt.fsm = BDR_FETCH;
          end
        end
      end
      BDR_FETCH: begin
        if (desc_rd_ack) begin
          if (!desc_rsp.own) begin
            ev[`BDR_ST_NOWN] = 1'b1;
            s_nxt.skip       = 1'b1;
            s_nxt.halt       = 1'b1;
            s_nxt.fsm        = BDR_IDLE;
          end else begin
            s_nxt.wptr = desc_rsp.buf_addr;
            s_nxt.nxt  = desc_rsp.next_ptr;
            s_nxt.cnt  = 16'h0;
            s_nxt.fsm  = BDR_MOVE;
          end
        end
      end
      BDR_MOVE: begin
        if (pop) begin
          if (s_r.cnt != 16'hffff) begin
            s_nxt.cnt = s_r.cnt + 16'h1;
          end
          if (fits) begin
            s_nxt.wptr = s_r.wptr + 26'h1;
          end
          if (len_hi_hit) begin
            s_nxt.len_hi = f_data[7:0];
          end
          if (len_lo_hit) begin
            s_nxt.flen        = {s_r.len_hi, f_data[7:0]};
            ev[`BDR_ST_EARLY] = 1'b1;
          end
          if (frm_end) begin
            // Length is cnt+1, so over the limit means cnt >= lsz
            if (!fits) begin
              ev[`BDR_ST_MSO] = 1'b1;
            end
            s_nxt.fsm = BDR_DONE;
          end
        end
      end
      BDR_DONE: begin
        ev[`BDR_ST_DONE] = 1'b1;
        s_nxt.ptr        = s_r.nxt;
        s_nxt.fsm        = BDR_IDLE;
      end
      default: begin
        // Unused codes of the state field fall back to idle
        s_nxt.fsm = BDR_IDLE;
      end
    endcase

    //------------------------------------------------------------
    // Register writes
    //------------------------------------------------------------
    if (reg_wr.en) begin
      unique case (reg_wr.addr)
        `BDR_OFS_CTRL: begin
          s_nxt.en = reg_wr.data[`BDR_CTRL_EN];
          if (reg_wr.data[`BDR_CTRL_RST]) begin
            // Receive reset drops any frame in flight
            s_nxt.fsm  = BDR_IDLE;
            s_nxt.halt = 1'b0;
            s_nxt.skip = 1'b0;
          end
        end
        `BDR_OFS_RXPTR: s_nxt.ptr  = reg_wr.data[25:0];
        `BDR_OFS_LSZ:   s_nxt.lsz  = reg_wr.data[15:0];
        // Status ignores zeros, so a done-only clear spares the rest
        `BDR_OFS_STAT:  clr        = reg_wr.data[5:0];
        `BDR_OFS_MASK:  s_nxt.mask = reg_wr.data[5:0];
        default: ;
      endcase
    end

    //------------------------------------------------------------
    // Status merge
    //------------------------------------------------------------
    // Empty re-sets every cycle the buffer holds nothing
    // Set beats clear in the same cycle
    s_nxt.stat = (s_r.stat & ~clr) | ev;
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r      <= '0;
      s_r.fsm  <= BDR_IDLE;
      // Pointer and limit wake at all ones, so an enable before
      // programming neither flags a null list nor cuts a frame
      s_r.ptr  <= `BDR_RXPTR_RST;
      s_r.lsz  <= `BDR_LSZ_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ===== sim/bdr_rx_dma_checker.sv
// Purpose: Port checks for the receive DMA block
// Assumes: One clock, sync reset
// Notes: Bound at foot of file
module bdr_rx_dma_checker
  import bdr_pkg::*;
#(parameter int BUF_DEPTH = 16) (
  input wire logic        clk_sys,      // clock
  input wire logic        srst,         // reset
  input wire logic        hreadyout,    // bus ready
  input wire logic        hresp,        // bus resp
  input wire logic        irq,          // interrupt
  input wire logic        mac_valid,    // byte offered
  input wire logic        mac_ready,    // byte taken
  input wire logic        desc_rd_req,  // fetch
  input wire logic [25:0] desc_rd_addr, // fetch addr
  input wire logic        desc_rd_ack,  // fetch ack
  input wire logic        mem_wr_valid, // mem write
  input wire bdr_memwr_t  mem_wr,       // mem addr/data
  input wire logic        mem_wr_ready  // mem accept
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_fetch;
    desc_rd_req && desc_rd_ack;
  endsequence
  sequence s_wr;
    mem_wr_valid && mem_wr_ready;
  endsequence
  property p_rst_quiet;
    $fell(srst) |-> !irq && !desc_rd_req && !mem_wr_valid && mac_ready;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_req_hold;
    desc_rd_req && !desc_rd_ack |=> desc_rd_req && $stable(desc_rd_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("fetch dropped early");
  property p_req_drop;
    s_fetch |=> !desc_rd_req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("fetch held after ack");
  property p_no_overlap;
    desc_rd_req |-> !mem_wr_valid;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("write while fetching");
  property p_wr_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write not held");
  property p_wr_seq;
    s_wr ##1 mem_wr_valid |-> mem_wr.addr == $past(mem_wr.addr) + 26'h1;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write address skipped");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready");
  property p_full;
    $fell(mac_ready) |-> $past(mac_valid);
  endproperty
  a_full: assert property (p_full) else $error("full without a byte");
endmodule
bind bdr_rx_dma bdr_rx_dma_checker #(.BUF_DEPTH(BUF_DEPTH)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
  .irq(irq), .mac_valid(mac_valid), .mac_ready(mac_ready),
  .desc_rd_req(desc_rd_req), .desc_rd_addr(desc_rd_addr),
  .desc_rd_ack(desc_rd_ack), .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr),
  .mem_wr_ready(mem_wr_ready));

// ===== sim/bdr_mem_model.sv
// Purpose: Descriptor and memory side partner
// Assumes: Descriptor at ptr, next at ptr plus 16
// Notes: Slow mode delays acks, toggles ready
module bdr_mem_model
  import bdr_pkg::*;
#(parameter logic [25:0] BUF = 26'h100) (
  input wire logic        clk_sys,      // clock
  input wire logic        srst,         // reset
  input wire logic        own,          // owner bit
  input wire logic        slow,         // stall
  input wire logic        desc_rd_req,  // fetch
  input wire logic [25:0] desc_rd_addr, // fetch addr
  input wire logic        mem_wr_valid, // write
  input wire bdr_memwr_t  mem_wr,       // write addr
  output logic            desc_rd_ack,  // fetch ack
  output bdr_desc_t       desc_rsp,     // descriptor
  output logic            mem_wr_ready, // accept
  output logic [31:0]     n_wr,         // bytes stored
  output logic [25:0]     last_addr,    // last stored
  output logic [7:0]      last_data     // last byte stored
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dly;
  always_ff @(posedge clk_sys) begin
    desc_rd_ack <= 1'b0;
    mem_wr_ready <= slow ? ~mem_wr_ready : 1'b1;
    if (srst) begin
      dly <= 2'h0;
      n_wr <= 32'h0;
    end else begin
      if (desc_rd_req && !desc_rd_ack) begin
        if (dly == (slow ? 2'h3 : 2'h0)) begin
          desc_rd_ack <= 1'b1;
          dly <= 2'h0;
        end else begin
          dly <= dly + 2'h1;
        end
      end
      if (mem_wr_valid && mem_wr_ready) begin
        n_wr <= n_wr + 32'h1;
        last_addr <= mem_wr.addr;
        last_data <= mem_wr.data;
      end
    end
  end
  // Content only with the ack, garbage otherwise
  assign desc_rsp = desc_rd_ack ? '{own, BUF, desc_rd_addr + 26'h10}
                                : '{~own, ~BUF, ~desc_rd_addr};
endmodule

// ===== sim/bdr_rx_dma_tb_top.sv
// Purpose: Self-checking bench for the receive DMA block
// Assumes: Zero-wait bus slave, buffer depth 16
// Notes: Frame rows first, then odd cases
`include "bdr_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module bdr_rx_dma_tb_top
  import bdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        srst, hsel, hwrite, mac_valid, mac_last, own, slow;
  logic [31:0] haddr, hwdata, hrdata, st, n_wr, w0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  mac_data, last_data;
  logic        hreadyout, hresp, mac_ready, desc_rd_req, desc_rd_ack;
  logic        mem_wr_valid, mem_wr_ready, irq;
  logic [25:0] desc_rd_addr, last_addr;
  bdr_desc_t   desc_rsp;
  bdr_memwr_t  mem_wr;
  int          n_mismatch, comparisons, cyc;
  int          rn[4] = '{20, 20, 14, 30};
  logic [15:0] rl[4] = '{16'h0014, 16'h0013, 16'h0064, 16'h0008};
  int          rw[4] = '{20, 19, 14, 8};
  logic        rm[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  bdr_rx_dma bdr_rx_dma_inst (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mac_valid(mac_valid), .mac_data(mac_data),
    .mac_last(mac_last), .mac_ready(mac_ready), .desc_rd_req(desc_rd_req),
    .desc_rd_addr(desc_rd_addr), .desc_rd_ack(desc_rd_ack), .desc_rsp(desc_rsp),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
    .irq(irq));
  bdr_mem_model bdr_mem_model_inst (.clk_sys(clk_sys), .srst(srst), .own(own),
    .slow(slow), .desc_rd_req(desc_rd_req), .desc_rd_addr(desc_rd_addr),
    .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr), .desc_rd_ack(desc_rd_ack),
    .desc_rsp(desc_rsp), .mem_wr_ready(mem_wr_ready), .n_wr(n_wr),
    .last_addr(last_addr), .last_data(last_data));
  // ------------------------------
  // Drivers
  // ------------------------------
  always #5 clk_sys = ~clk_sys;
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {16'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (!hreadyout);
    st = hrdata;
  endtask
  task automatic poll(input logic [31:0] m);
    for (int k = 0; k < 60; k++) begin
      bus(1'b0, `BDR_OFS_STAT, 32'h0);
      if (|(st & m)) break;
    end
  endtask
  task automatic frame(input int n);
    for (int i = 0; i < n; i++) begin
      mac_valid <= 1'b1;
      mac_data <= (i == 12) ? n[15:8] : (i == 13) ? n[7:0] : i[7:0];
      mac_last <= (i == n - 1);
      do @(posedge clk_sys); while (!mac_ready);
    end
    mac_valid <= 1'b0;
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    {hsel, hwrite, mac_valid, mac_last, slow, htrans} = '0;
    {haddr, hwdata, mac_data} = '0;
    srst = 1'b1;
    own = 1'b1;
    hsize = 3'h2;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    // Empty sets at the first edge after release, so status is read second
    bus(1'b0, `BDR_OFS_LSZ, 32'h0);
    `CHK(st, 32'h0000ffff)
    bus(1'b0, `BDR_OFS_STAT, 32'h0);
    `CHK(st, 32'h00000010)
    bus(1'b0, `BDR_OFS_RXPTR, 32'h0);
    `CHK(st, 32'h03ffffff)
    bus(1'b0, 16'h9020, 32'h0);
    `CHK(st, 32'h0)
    for (int r = 0; r < 4; r++) begin
      slow <= r[0];
      bus(1'b1, `BDR_OFS_CTRL, 32'h2);
      bus(1'b1, `BDR_OFS_RXPTR, 32'h40);
      bus(1'b1, `BDR_OFS_LSZ, {16'h0, rl[r]});
      bus(1'b1, `BDR_OFS_MASK, 32'h1);
      bus(1'b1, `BDR_OFS_STAT, 32'h3f);
      w0 = n_wr;
      bus(1'b1, `BDR_OFS_CTRL, 32'h1);
      frame(rn[r]);
      poll(32'h1);
      `CHK(st, {26'h0, 2'b11, rm[r], 3'b001})
      `CHK(n_wr - w0, 32'(rw[r]))
      `CHK(last_addr, 26'(32'h100 + rw[r] - 1))
      `CHK(last_data, (rw[r] == 14) ? 8'(rn[r]) : 8'(rw[r] - 1))
      `CHK(irq, 1'b1)
      bus(1'b0, `BDR_OFS_LSZ, 32'h0);
      `CHK(st, {rn[r][15:0], rl[r]})
      bus(1'b0, `BDR_OFS_RXPTR, 32'h0);
      `CHK(st, 32'h00000050)
      bus(1'b1, `BDR_OFS_STAT, 32'h1);
      @(posedge clk_sys);
      `CHK(irq, 1'b0)
    end
    own <= 1'b0;
    bus(1'b1, `BDR_OFS_CTRL, 32'h2);
    bus(1'b1, `BDR_OFS_RXPTR, 32'h40);
    bus(1'b1, `BDR_OFS_STAT, 32'h3f);
    bus(1'b1, `BDR_OFS_CTRL, 32'h1);
    poll(32'h4);
    `CHK(st, 32'h00000014)
    bus(1'b0, `BDR_OFS_CTRL, 32'h0);
    `CHK(st, 32'h00010005)
    own <= 1'b1;
    bus(1'b1, `BDR_OFS_CTRL, 32'h2);
    bus(1'b1, `BDR_OFS_RXPTR, 32'h0);
    bus(1'b1, `BDR_OFS_MASK, 32'h2);
    bus(1'b1, `BDR_OFS_STAT, 32'h3f);
    bus(1'b1, `BDR_OFS_CTRL, 32'h1);
    poll(32'h2);
    `CHK(st, 32'h00000012)
    `CHK(irq, 1'b1)
    bus(1'b1, `BDR_OFS_STAT, 32'h2);
    bus(1'b0, `BDR_OFS_STAT, 32'h0);
    `CHK(st, 32'h00000010)
    `CHK(irq, 1'b0)
    bus(1'b1, `BDR_OFS_CTRL, 32'h2);
    frame(16);
    @(posedge clk_sys);
    `CHK(mac_ready, 1'b0)
    bus(1'b1, `BDR_OFS_STAT, 32'h3f);
    bus(1'b0, `BDR_OFS_STAT, 32'h0);
    `CHK(st, 32'h0)
    conclude();
  end
endmodule
